// ===== shp_pkg.sv
package shp_pkg;

  // ==========================================================
  // word and counter sizes
  localparam int WORD_W   = 8;
  localparam int CNT_W    = 4;
  localparam int DIV_W    = 4;
  localparam int SYNC_W   = 7;
  localparam int ADDR_W   = 7;

  // ==========================================================
  // timing of the generated serial clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_HALF_NS   = 200;
  localparam int SCK_HALF_RAW  = SCK_HALF_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC  = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;
  localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(SCK_HALF_CYC - 1);

  // ==========================================================
  // field positions and constant values
  localparam int ADDR_PIN0_POS = 0;
  localparam int ADDR_PIN2_POS = 2;
  localparam logic [3:0] I2C_ADDR_HI = 4'h1;
  localparam logic [1:0] REQ_MODE_OFF = 2'h0;

  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST  = 7'h00;
  localparam logic              OE_N_RST  = 1'b1;
  localparam logic              ARMED_RST = 1'b1;
  localparam logic              SCK_RST   = 1'b0;

  typedef enum logic [1:0] {
    MODE_SPI_SLAVE  = 2'h0,
    MODE_SPI_MASTER = 2'h1,
    MODE_I2C_SLAVE  = 2'h2,
    MODE_I2C_MASTER = 2'h3
  } port_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } xfer_state_t;

endpackage

// ===== word_buf_if.sv
interface word_buf_if import shp_pkg::*; ();
  logic              in_valid;
  logic              in_ready;
  logic [WORD_W-1:0] in_data;
  logic              out_valid;
  logic              out_ready;
  logic [WORD_W-1:0] out_data;

  modport buffer (input  in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
  modport user   (output in_valid, in_data, out_ready,
                  input  in_ready, out_valid, out_data);
endinterface

// ===== word_buffer.sv
module word_buffer
  import shp_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  word_buf_if.buffer        b
);

  logic [WORD_W-1:0] head_ff;
  logic [WORD_W-1:0] tail_ff;
  logic              head_v_ff;
  logic              tail_v_ff;

  wire push = b.in_valid & ~tail_v_ff;
  wire pop  = head_v_ff & b.out_ready;

  // ==========================================================
  // two-entry skid: head feeds the output, tail absorbs a stall
  wire               nxt_head_v = pop ? (tail_v_ff | push) : (head_v_ff | push);
  wire               nxt_tail_v = pop ? (tail_v_ff & push)
                                      : (tail_v_ff | (push & head_v_ff));
  wire [WORD_W-1:0]  nxt_head   = pop ? (tail_v_ff ? tail_ff : b.in_data)
                                      : (head_v_ff ? head_ff : b.in_data);
  wire [WORD_W-1:0]  nxt_tail   = push ? b.in_data : tail_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
    end else begin
      head_v_ff <= nxt_head_v;
      tail_v_ff <= nxt_tail_v;
    end
  end

  always_ff @(posedge clk_i) begin
    head_ff <= nxt_head;
    tail_ff <= nxt_tail;
  end

  assign b.in_ready  = ~tail_v_ff;
  assign b.out_valid = head_v_ff;
  assign b.out_data  = head_ff;

endmodule // word_buffer

// ===== serial_host_port.sv
// Operation
// - master drives mosi; slave receives mosi
// - i2c slave uses address pin 0
// - i2c master ignores address pin 0
// - i2c slave uses address pin 2
// - i2c master ignores address pin 2
// - address pins undriven and unsampled in reset
// - slave transfers only while select low
// - select low in master raises bus error
// - select high: ignore clocks, miso released
// - slave asserts host request when ready
// - slave drops request at first clock
// - master starts word on host request
// - master waits fresh request after word
// - request pin released in reset, mode off
// - miso input in master, output in slave while selected
// - master makes clock; slave takes it in
module serial_host_port
  import shp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              soft_reset_i,
  input  wire logic [1:0]        mode_i,
  input  wire logic [1:0]        request_mode_i,
  input  wire logic              bus_error_clr_i,
  output wire logic              bus_error_o,
  input  wire logic              sck_i,
  output wire logic              sck_o,
  output wire logic              sck_oe_n_o,
  input  wire logic              mosi_i,
  output wire logic              mosi_o,
  output wire logic              mosi_oe_n_o,
  input  wire logic              miso_i,
  output wire logic              miso_o,
  output wire logic              miso_oe_n_o,
  input  wire logic              slave_select_n_i,
  input  wire logic              host_request_i,
  output wire logic              host_request_o,
  output wire logic              host_request_oe_n_o,
  input  wire logic              slave_addr_pin0_i,
  input  wire logic              slave_addr_pin2_i,
  output wire logic [ADDR_W-1:0] i2c_own_addr_o,
  input  wire logic [WORD_W-1:0] tx_data_i,
  input  wire logic              tx_valid_i,
  output wire logic              tx_ready_o,
  output wire logic [WORD_W-1:0] rx_data_o,
  output wire logic              rx_valid_o,
  input  wire logic              rx_ready_i
);

  // ==========================================================
  // reset and mode decode
  wire port_rst       = ~reset_n_i | soft_reset_i;
  wire port_rst_n     = ~port_rst;
  wire is_spi_slave   = (mode_i == MODE_SPI_SLAVE);
  wire is_spi_master  = (mode_i == MODE_SPI_MASTER);
  wire is_i2c_slave   = (mode_i == MODE_I2C_SLAVE);
  wire is_slave_role  = is_spi_slave | is_i2c_slave;
  wire req_en         = (request_mode_i != REQ_MODE_OFF);

  // ==========================================================
  // pin synchronisers
  wire  [SYNC_W-1:0] pin_raw = {sck_i, mosi_i, miso_i, slave_select_n_i,
                                host_request_i, slave_addr_pin2_i,
                                slave_addr_pin0_i};
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        // sck flops start at its idle level: no false edge
        if (port_rst) begin
          sync1_ff[gi] <= (gi == SYNC_W - 1) ? SCK_RST : 1'b1;
          sync2_ff[gi] <= (gi == SYNC_W - 1) ? SCK_RST : 1'b1;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  wire sck_s   = sync2_ff[6];
  wire mosi_s  = sync2_ff[5];
  wire miso_s  = sync2_ff[4];
  wire ss_act  = ~sync2_ff[3];
  wire host_request_act = ~sync2_ff[2];
  wire addr2_s = sync2_ff[1];
  wire addr0_s = sync2_ff[0];

  // ==========================================================
  // state
  xfer_state_t       state_ff;
  xfer_state_t       nxt_state;
  logic [CNT_W-1:0]  bit_cnt_ff;
  logic [DIV_W-1:0]  div_ff;
  logic              sck_d_ff;
  logic              sck_out_ff;
  logic [WORD_W-1:0] shift_tx_ff;
  logic [WORD_W-1:0] shift_rx_ff;
  logic [WORD_W-1:0] tx_hold_ff;
  logic              tx_full_ff;
  logic              tx_ready_ff;
  logic              loaded_ff;
  logic              armed_ff;
  logic              host_request_n_ff;
  logic              bus_error_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic              sck_oe_n_ff;
  logic              mosi_oe_n_ff;
  logic              miso_oe_n_ff;
  logic              host_request_oe_n_ff;

  word_buf_if rxb ();

  word_buffer u_rx_buffer (
    .clk_i     (clk_i),
    .reset_n_i (port_rst_n),
    .b         (rxb.buffer)
  );

  // ==========================================================
  // edge and event decode
  wire in_idle    = (state_ff == ST_IDLE);
  wire in_xfer    = (state_ff == ST_XFER);
  wire in_done    = (state_ff == ST_DONE);
  wire sck_rise   = sck_s & ~sck_d_ff;
  wire sck_fall   = ~sck_s & sck_d_ff;
  wire slave_ok   = is_spi_slave & ss_act;
  wire div_done   = (div_ff == '0);
  wire m_rise     = is_spi_master & in_xfer & div_done & ~sck_out_ff;
  wire m_fall     = is_spi_master & in_xfer & div_done & sck_out_ff;
  wire s_start    = in_idle & slave_ok & sck_rise;
  wire m_go       = req_en ? (armed_ff & host_request_act) : 1'b1;
  wire m_start    = is_spi_master & in_idle & loaded_ff & m_go;
  wire sample     = is_spi_master ? m_rise
                                  : (slave_ok & sck_rise & (in_xfer | in_idle));
  wire shift      = m_fall | (slave_ok & sck_fall & in_xfer);
  wire sample_bit = is_spi_master ? miso_s : mosi_s;
  wire last_bit   = (bit_cnt_ff == CNT_W'(WORD_W - 1));
  wire word_end   = sample & last_bit & in_xfer;
  wire s_abort    = is_spi_slave & in_xfer & ~ss_act;
  wire can_load   = in_idle & ~loaded_ff & tx_full_ff & rxb.in_ready
                    & (is_slave_role | is_spi_master);
  wire tx_accept  = tx_valid_i & tx_ready_ff;

  // ==========================================================
  // transfer sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (m_start | s_start) begin
          nxt_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (s_abort) begin
          nxt_state = ST_IDLE;
        end else if (word_end) begin
          nxt_state = is_spi_master ? ST_DONE : ST_IDLE;
        end
      end
      ST_DONE: begin
        if (div_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  wire [CNT_W-1:0] nxt_bit_cnt =
    (in_idle | s_abort)  ? (s_start ? CNT_W'(1) : '0) :
    sample               ? bit_cnt_ff + CNT_W'(1) : bit_cnt_ff;
  wire [DIV_W-1:0] nxt_div =
    (m_start | div_done) ? DIV_RELOAD : div_ff - DIV_W'(1);
  wire nxt_sck_out =
    (in_xfer & is_spi_master & div_done) ? ~sck_out_ff :
    (in_done & div_done)                 ? 1'b0 : sck_out_ff;
  wire [WORD_W-1:0] nxt_shift_tx =
    can_load ? tx_hold_ff :
    shift    ? {shift_tx_ff[WORD_W-2:0], 1'b0} : shift_tx_ff;
  wire [WORD_W-1:0] nxt_shift_rx =
    sample ? {shift_rx_ff[WORD_W-2:0], sample_bit} : shift_rx_ff;
  wire nxt_tx_full = (tx_full_ff & ~can_load) | tx_accept;
  wire nxt_loaded  = (loaded_ff | can_load) & ~(m_start | s_start);
  wire nxt_armed   = (armed_ff | ~host_request_act) & ~m_start;
  wire nxt_bus_err = (is_spi_master & ss_act)
                     | (bus_error_ff & ~bus_error_clr_i);
  wire [ADDR_W-1:0] slave_addr = {I2C_ADDR_HI, addr2_s, 1'b0, addr0_s};
  wire [ADDR_W-1:0] nxt_addr =
    is_i2c_slave ? slave_addr : addr_ff;

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= '0;
      div_ff     <= DIV_RELOAD;
      sck_d_ff   <= SCK_RST;
      sck_out_ff <= SCK_RST;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      div_ff     <= nxt_div;
      sck_d_ff   <= sck_s;
      sck_out_ff <= nxt_sck_out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      shift_tx_ff <= '0;
      shift_rx_ff <= '0;
      tx_hold_ff  <= '0;
      tx_full_ff  <= 1'b0;
      tx_ready_ff <= 1'b0;
    end else begin
      shift_tx_ff <= nxt_shift_tx;
      shift_rx_ff <= nxt_shift_rx;
      tx_hold_ff  <= tx_accept ? tx_data_i : tx_hold_ff;
      tx_full_ff  <= nxt_tx_full;
      tx_ready_ff <= ~nxt_tx_full;
    end
  end

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      loaded_ff    <= 1'b0;
      armed_ff     <= ARMED_RST;
      host_request_n_ff    <= 1'b1;
      bus_error_ff <= 1'b0;
      addr_ff      <= ADDR_RST;
    end else begin
      loaded_ff    <= nxt_loaded;
      armed_ff     <= nxt_armed;
      host_request_n_ff    <= ~nxt_loaded;
      bus_error_ff <= nxt_bus_err;
      addr_ff      <= nxt_addr;
    end
  end

  // ==========================================================
  // pin direction
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      sck_oe_n_ff  <= OE_N_RST;
      mosi_oe_n_ff <= OE_N_RST;
      miso_oe_n_ff <= OE_N_RST;
      host_request_oe_n_ff <= OE_N_RST;
    end else begin
      sck_oe_n_ff  <= ~is_spi_master;
      mosi_oe_n_ff <= ~is_spi_master;
      miso_oe_n_ff <= ~slave_ok;
      host_request_oe_n_ff <= ~(is_slave_role & req_en);
    end
  end

  assign rxb.in_valid  = word_end;
  assign rxb.in_data   = {shift_rx_ff[WORD_W-2:0], sample_bit};
  assign rxb.out_ready = rx_ready_i;

  assign sck_o               = sck_out_ff;
  assign sck_oe_n_o          = sck_oe_n_ff;
  assign mosi_o              = shift_tx_ff[WORD_W-1];
  assign mosi_oe_n_o         = mosi_oe_n_ff;
  assign miso_o              = shift_tx_ff[WORD_W-1];
  assign miso_oe_n_o         = miso_oe_n_ff;
  assign host_request_o      = host_request_n_ff;
  assign host_request_oe_n_o = host_request_oe_n_ff;
  assign bus_error_o         = bus_error_ff;
  assign i2c_own_addr_o      = addr_ff;
  assign tx_ready_o          = tx_ready_ff;
  assign rx_data_o           = rxb.out_data;
  assign rx_valid_o          = rxb.out_valid;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (port_rst);

  sequence seq_slave_ready;
    is_spi_slave && req_en && in_idle && loaded_ff;
  endsequence

  sequence seq_first_edge;
    seq_slave_ready ##0 (ss_act && sck_rise);
  endsequence

  mosi_drive_a: assert property (
    is_spi_master |=> !mosi_oe_n_o || !reset_n_i)
    else $error("mosi not driven in spi master");

  mosi_in_a: assert property (
    is_spi_slave && $stable(mode_i) |=> mosi_oe_n_o)
    else $error("mosi driven in spi slave");

  addr_pin0_a: assert property (
    is_i2c_slave |=> i2c_own_addr_o[ADDR_PIN0_POS] == $past(addr0_s))
    else $error("address bit 0 not from pin");

  addr_pin2_a: assert property (
    is_i2c_slave |=> i2c_own_addr_o[ADDR_PIN2_POS] == $past(addr2_s))
    else $error("address bit 2 not from pin");

  addr_master_a: assert property (
    (mode_i == MODE_I2C_MASTER) |=> $stable(i2c_own_addr_o))
    else $error("address changed in i2c master");

  err_flag_a: assert property (
    is_spi_master && ss_act |=> bus_error_o)
    else $error("bus error not flagged");

  err_sticky_a: assert property (
    bus_error_o && !bus_error_clr_i |=> bus_error_o)
    else $error("bus error dropped without clear");

  miso_hiz_a: assert property (
    !ss_act |=> miso_oe_n_o)
    else $error("miso driven while deselected");

  ignore_sck_a: assert property (
    is_spi_slave && !ss_act && in_idle |=> in_idle)
    else $error("transfer started while deselected");

  host_request_drop_a: assert property (
    seq_first_edge |=> host_request_o ##1 host_request_o)
    else $error("host request held after first edge");

  host_request_ready_a: assert property (
    seq_slave_ready ##0 !(ss_act && sck_rise) |=> !host_request_o)
    else $error("host request not asserted when ready");

  fresh_req_a: assert property (
    is_spi_master && req_en && in_idle ##1 in_xfer
      |-> $past(armed_ff) && $past(host_request_act))
    else $error("master started without fresh request");

  host_request_off_a: assert property (
    !req_en |=> host_request_oe_n_o)
    else $error("host request driven with mode off");

endmodule // serial_host_port

// ===== spi_far_end.sv
module spi_far_end (
  input  wire logic clk_i,
  input  wire logic dev_sck_i,
  input  wire logic mosi_pin_i,
  input  wire logic miso_pin_i,
  output logic      link_sck_o,
  output logic      link_mosi_o,
  output logic      link_miso_o,
  output logic      select_n_o,
  output logic      request_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       busy;
  logic [7:0] caught;

  // ==========================================================
  // idle levels; released data lines keep changing
  initial begin
    busy = 1'b0;
    link_sck_o = 1'b0;
    link_mosi_o = 1'b0;
    link_miso_o = 1'b0;
    select_n_o = 1'b1;
    request_n_o = 1'b1;
  end

  always @(posedge clk_i) begin
    if (!busy) begin
      link_mosi_o <= ~link_mosi_o;
      link_miso_o <= ~link_miso_o;
    end
  end

  // ==========================================================
  // far end as master: mode 0, 400 ns period
  task automatic frame(input logic [7:0] tx, input logic sel,
                       output logic [7:0] rx);
    busy = 1'b1;
    select_n_o = ~sel;
    link_mosi_o = tx[7];
    #400;
    for (int i = 0; i < 8; i++) begin
      link_sck_o = 1'b1;
      #199;
      rx = {rx[6:0], miso_pin_i};
      #1;
      link_sck_o = 1'b0;
      #100;
      tx = tx << 1;
      link_mosi_o = tx[7];
      #100;
    end
    select_n_o = 1'b1;
    busy = 1'b0;
  endtask

  // ==========================================================
  // far end as slave: follows the device clock
  task automatic serve(input logic [7:0] tx);
    busy = 1'b1;
    link_miso_o = tx[7];
    for (int i = 0; i < 8; i++) begin
      @(posedge dev_sck_i);
      caught = {caught[6:0], mosi_pin_i};
      @(negedge dev_sck_i);
      #5;
      tx = tx << 1;
      link_miso_o = tx[7];
    end
    busy = 1'b0;
  endtask
endmodule // spi_far_end

// ===== test_serial_host_port.sv
`define check_eq(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s: expected %h seen %h", what, exp, got); \
    end \
  end

module test_serial_host_port import shp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              soft_reset_i = 1'b0;
  logic [1:0]        mode_i = 2'h0;
  logic [1:0]        request_mode_i = 2'h1;
  logic              bus_error_clr_i = 1'b0;
  logic              pin0 = 1'b0;
  logic              pin2 = 1'b0;
  logic [WORD_W-1:0] tx_data_i = 8'h00;
  logic              tx_valid_i = 1'b0;
  logic              rx_ready_i = 1'b0;
  logic              bus_error_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o;
  logic              miso_o, miso_oe_n_o, host_request_o;
  logic              host_request_oe_n_o, tx_ready_o, rx_valid_o;
  logic [ADDR_W-1:0] i2c_own_addr_o;
  logic [WORD_W-1:0] rx_data_o;
  logic              link_sck, link_mosi, link_miso, select_n, request_n;
  logic              sck_w, mosi_w, miso_w, req_w;
  logic [ADDR_W-1:0] want;
  logic [WORD_W-1:0] t, m, got;
  logic [WORD_W-1:0] bw [4];
  logic [WORD_W-1:0] tw [4];
  logic [WORD_W-1:0] exp_q [$];
  int                miscompares = 0;
  int                check_count = 0;

  // ==========================================================
  // pin levels from all drivers
  assign sck_w = !sck_oe_n_o ? sck_o : link_sck;
  assign mosi_w = !mosi_oe_n_o ? mosi_o : link_mosi;
  assign miso_w = !miso_oe_n_o ? miso_o : link_miso;
  assign req_w = !host_request_oe_n_o ? host_request_o : request_n;

  serial_host_port serial_host_port_i (
    .clk_i, .reset_n_i, .soft_reset_i, .mode_i, .request_mode_i,
    .bus_error_clr_i, .bus_error_o, .sck_i(sck_w), .sck_o, .sck_oe_n_o,
    .mosi_i(mosi_w), .mosi_o, .mosi_oe_n_o, .miso_i(miso_w), .miso_o,
    .miso_oe_n_o, .slave_select_n_i(select_n), .host_request_i(req_w),
    .host_request_o, .host_request_oe_n_o, .slave_addr_pin0_i(pin0),
    .slave_addr_pin2_i(pin2), .i2c_own_addr_o, .tx_data_i, .tx_valid_i,
    .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_ready_i);

  spi_far_end spi_far_end_i (
    .clk_i, .dev_sck_i(sck_w), .mosi_pin_i(mosi_w), .miso_pin_i(miso_w),
    .link_sck_o(link_sck), .link_mosi_o(link_mosi),
    .link_miso_o(link_miso), .select_n_o(select_n),
    .request_n_o(request_n));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================
  // shared tasks
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic send(input logic [WORD_W-1:0] d);
    int n;
    n = 0;
    while (tx_ready_o !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
    `check_eq("tx ready", 1'b1, tx_ready_o)
    tx_data_i = d;
    tx_valid_i = 1'b1;
    tick();
    tx_valid_i = 1'b0;
  endtask

  task automatic take(input string what);
    int n;
    logic [WORD_W-1:0] e;
    n = 0;
    while (rx_valid_o !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    `check_eq("rx valid", 1'b1, rx_valid_o)
    e = exp_q.pop_front();
    `check_eq(what, e, rx_data_o)
    rx_ready_i = 1'b1;
    tick();
    rx_ready_i = 1'b0;
    tick();
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #500us;
    miscompares++;
    $display("watchdog expired");
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(70));
    tick(3);
    `check_eq("req oe rst", 1'b1, host_request_oe_n_o)
    `check_eq("miso oe rst", 1'b1, miso_oe_n_o)
    `check_eq("addr rst", 7'h00, i2c_own_addr_o)
    reset_n_i = 1'b1;
    tick(2);
    done("reset");
    for (int k = 0; k < 4; k++) begin
      mode_i = MODE_I2C_SLAVE;
      pin0 = 1'($urandom);
      pin2 = 1'($urandom);
      tick(5);
      want = {I2C_ADDR_HI, pin2, 1'b0, pin0};
      `check_eq("own addr", want, i2c_own_addr_o)
      mode_i = MODE_I2C_MASTER;
      tick(2);
      pin0 = ~pin0;
      pin2 = ~pin2;
      tick(5);
      `check_eq("addr kept", want, i2c_own_addr_o)
    end
    done("address");
    mode_i = MODE_SPI_SLAVE;
    t = WORD_W'($urandom);
    send(t);
    tick(6);
    `check_eq("req low", 1'b0, host_request_o)
    fork
      spi_far_end_i.frame(8'ha5, 1'b0, got);
      begin
        #1000;
        `check_eq("miso off", 1'b1, miso_oe_n_o)
      end
    join
    `check_eq("req kept", 1'b0, host_request_o)
    for (int j = 0; j < 2; j++) begin
      if (j > 0) begin
        t = WORD_W'($urandom);
        send(t);
        tick(6);
      end
      m = WORD_W'($urandom);
      fork
        spi_far_end_i.frame(m, 1'b1, got);
        begin
          #1000;
          `check_eq("req mid", 1'b1, host_request_o)
          `check_eq("miso on", 1'b0, miso_oe_n_o)
        end
      join
      `check_eq("miso word", t, got)
      exp_q.push_back(m);
    end
    take("slave rx 0");
    take("slave rx 1");
    request_mode_i = REQ_MODE_OFF;
    tick(2);
    `check_eq("req off", 1'b1, host_request_oe_n_o)
    request_mode_i = 2'h1;
    done("slave");
    mode_i = MODE_SPI_MASTER;
    tick(4);
    `check_eq("sck oe", 1'b0, sck_oe_n_o)
    `check_eq("mosi oe", 1'b0, mosi_oe_n_o)
    `check_eq("miso in", 1'b1, miso_oe_n_o)
    for (int j = 0; j < 2; j++) begin
      t = WORD_W'($urandom);
      m = WORD_W'($urandom);
      exp_q.push_back(m);
      fork
        spi_far_end_i.serve(m);
      join_none
      send(t);
      tick(80);
      `check_eq("no start", 1'b0, rx_valid_o)
      spi_far_end_i.request_n_o = 1'b1;
      tick(4);
      spi_far_end_i.request_n_o = 1'b0;
      take("master rx");
      `check_eq("mosi word", t, spi_far_end_i.caught)
      wait (spi_far_end_i.busy == 1'b0);
    end
    spi_far_end_i.request_n_o = 1'b1;
    done("master");
    request_mode_i = REQ_MODE_OFF;
    for (int k = 0; k < 4; k++) begin
      bw[k] = WORD_W'($urandom);
      tw[k] = WORD_W'($urandom);
      exp_q.push_back(bw[k]);
    end
    fork
      for (int k = 0; k < 4; k++) spi_far_end_i.serve(bw[k]);
      for (int k = 0; k < 4; k++) send(tw[k]);
    join_none
    tick(400);
    `check_eq("buffer full", 1'b0, tx_ready_o)
    for (int k = 0; k < 4; k++) take("buffered rx");
    done("buffer");
    spi_far_end_i.select_n_o = 1'b0;
    tick(5);
    `check_eq("bus err set", 1'b1, bus_error_o)
    spi_far_end_i.select_n_o = 1'b1;
    tick(5);
    `check_eq("bus err held", 1'b1, bus_error_o)
    bus_error_clr_i = 1'b1;
    tick();
    bus_error_clr_i = 1'b0;
    tick();
    `check_eq("bus err clr", 1'b0, bus_error_o)
    done("bus error");
    mode_i = MODE_SPI_SLAVE;
    request_mode_i = 2'h1;
    tick(2);
    `check_eq("req drive", 1'b0, host_request_oe_n_o)
    soft_reset_i = 1'b1;
    tick(2);
    `check_eq("req soft rst", 1'b1, host_request_oe_n_o)
    `check_eq("sck soft rst", 1'b1, sck_oe_n_o)
    soft_reset_i = 1'b0;
    tick(2);
    done("soft reset");
    conclude();
  end
endmodule // test_serial_host_port
